// file: hw/asr_pkg.sv
`default_nettype none
package asr_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0] OFS_INTCTL  = 8'h0B;
  localparam logic [7:0] OFS_PIRF    = 8'h0C;
  localparam logic [7:0] OFS_RCSC    = 8'h18;
  localparam logic [7:0] OFS_TXDATA  = 8'h19;
  localparam logic [7:0] OFS_RXBUF   = 8'h1A;
  localparam logic [7:0] OFS_PIEN    = 8'h8C;
  localparam logic [7:0] OFS_TXSC    = 8'h98;
  localparam logic [7:0] OFS_BAUD    = 8'h99;
  localparam logic [7:0] OFS_PORTDIR = 8'h86;
  // ==========================================
  // Field positions
  localparam int B_SERIAL_PORT_ENABLE = 7;
  localparam int B_RX9  = 6;
  localparam int B_SINGLE_RECEIVE_ENABLE = 5;
  localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int B_ADEN = 3;
  localparam int B_FRAMING_ERROR = 2;
  localparam int B_OVERRUN_ERROR = 1;
  localparam int B_RECEIVED_NINTH_BIT = 0;
  localparam int B_SYNC = 4;
  localparam int B_HIGH_BAUD_SELECT = 2;
  localparam int B_TX_SHIFT_EMPTY = 1;
  localparam int B_RECEIVE_IRQ_FLAG = 5;
  localparam int B_RXPIN = 2;
  localparam int B_TXPIN = 5;
  // ==========================================
  // Reset values
  localparam logic [7:0] RST_TXSC    = 8'h02;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_PORTDIR = 8'hFF;
  // ==========================================
  // Timing
  localparam logic [3:0] OVS_LAST  = 4'hF;
  localparam logic [3:0] OVS_MID   = 4'h7;
  localparam int         CLK_HZ    = 25000000;
  typedef enum logic [1:0] {
    ASR_IDLE  = 2'b00,
    ASR_START = 2'b01,
    ASR_DATA  = 2'b10,
    ASR_STOP  = 2'b11
  } asr_rx_state_t;
endpackage
`default_nettype wire

// file: hw/asr_fifo.sv
`default_nettype none
module asr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    wr_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else if (flush) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  always_ff @(posedge clock) begin
    if (do_wr)
      mem[wr_ptr] <= in_data;
  end
endmodule
`default_nettype wire

// file: hw/asr_top.sv
// How it works
// RULE1: Async, sync master, sync slave modes selectable; here the sync bit holds the receiver idle and blocks transmit loads.
// RULE2: Pins owned only with enable and directions.
// RULE3: Address characters detected in nine-bit frames.
// RULE4: High baud bit speeds async only.
// RULE5: Receive pin feeds the recovery stage.
// RULE6: Sixteen-times oversampling, shift at bit rate.
// RULE7: Async frames accepted only while receive enabled.
// RULE8: Stop bit moves byte, sets flag.
// RULE9: Interrupt passed only when enable set.
// RULE10: Flag read-only, clears when buffer empty.
// RULE11: Two-deep buffer plus shift register.
// RULE12: Full buffer at stop sets overrun.
// RULE13: Overrun blocks all further transfers.
// RULE14: Overrun clears only by receive enable toggle.
// RULE15: Low stop bit sets framing error.
// RULE16: Status bits queued with each byte.
// RULE17: Software reads status before buffer.
// RULE18: Eight-bit baud divisor, reset to zero.
// RULE19: Transmit shift empty read-only, resets one.
`default_nettype none
module asr_top
  import asr_pkg::*;
#(
  parameter int RX_DEPTH = 2,
  parameter int TX_DEPTH = 8
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Serial pins
  input  wire logic       receive_data_pin,
  output logic            transmit_clock_pin,
  output logic            transmit_clock_pin_oe,
  // Interrupt request
  output logic            receive_irq
);
  import asr_pkg::*;

  // ==========================================
  // Registers
  logic [7:0] rcsc;
  logic [7:0] txsc;
  logic [7:0] baud_divisor;
  logic [7:0] pien;
  logic [7:0] intctl;
  logic [7:0] portdir;
  logic       overrun_error;
  logic       continuous_receive_enable_q;
  logic       rd_buf;
  logic       wr_tx;

  assign rd_buf = reg_rd && reg_addr == OFS_RXBUF;
  assign wr_tx  = reg_wr && reg_addr == OFS_TXDATA;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rcsc         <= RST_ZERO;
      txsc         <= RST_TXSC;
      baud_divisor <= RST_ZERO; // RULE18
      pien         <= RST_ZERO;
      intctl       <= RST_ZERO;
      portdir      <= RST_PORTDIR;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_RCSC:    rcsc <= {reg_wdata[7:3], 3'h0};
        OFS_TXSC:    txsc <= {reg_wdata[7:4], 1'b0, reg_wdata[2], 1'b0, reg_wdata[0]}; // RULE1 RULE4
        OFS_BAUD:    baud_divisor <= reg_wdata; // RULE18
        OFS_PIEN:    pien <= reg_wdata;
        OFS_INTCTL:  intctl <= reg_wdata;
        OFS_PORTDIR: portdir <= reg_wdata;
        default:     rcsc <= rcsc;
      endcase
    end
  end

  logic sync_mode;
  logic serial_on;
  assign sync_mode = txsc[B_SYNC]; // RULE1
  assign serial_on = rcsc[B_SERIAL_PORT_ENABLE] && portdir[B_RXPIN] && portdir[B_TXPIN]; // RULE2

  // ==========================================
  // Baud tick at x16 rate
  // Async low speed divides by 4 more than high speed; sync ignores the speed bit.
  logic [9:0] bdiv_cnt;
  logic [9:0] bdiv_top;
  logic       os_tick;
  always_comb begin
    if (!sync_mode && !txsc[B_HIGH_BAUD_SELECT])
      bdiv_top = {baud_divisor, 2'b11}; // RULE4
    else
      bdiv_top = {2'b00, baud_divisor};
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bdiv_cnt <= '0;
      os_tick  <= 1'b0;
    end else if (bdiv_cnt >= bdiv_top) begin
      bdiv_cnt <= '0;
      os_tick  <= 1'b1;
    end else begin
      bdiv_cnt <= bdiv_cnt + 10'h001;
      os_tick  <= 1'b0;
    end
  end

  // ==========================================
  // Receiver
  asr_rx_state_t rx_state;
  logic [3:0]    os_cnt;
  logic [3:0]    bit_cnt;
  logic [8:0]    receive_shift_register;
  logic          rx_in;
  logic          rx_en;
  logic          stop_evt;
  logic          stop_low;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic [9:0]    fifo_out;
  logic [3:0]    nbits;

  assign rx_in = serial_on ? receive_data_pin : 1'b1; // RULE5 RULE2
  assign rx_en = serial_on && !sync_mode && rcsc[B_CONTINUOUS_RECEIVE_ENABLE]; // RULE7
  assign nbits = rcsc[B_RX9] ? 4'h9 : 4'h8; // RULE3

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_state               <= ASR_IDLE;
      os_cnt                 <= '0;
      bit_cnt                <= '0;
      receive_shift_register <= '0;
      stop_evt               <= 1'b0;
      stop_low               <= 1'b0;
    end else begin
      stop_evt <= 1'b0;
      if (!rx_en) begin
        rx_state <= ASR_IDLE; // RULE7
      end else if (os_tick) begin // RULE6
        os_cnt <= os_cnt + 4'h1;
        case (rx_state)
          ASR_IDLE: begin
            if (!rx_in) begin
              rx_state <= ASR_START;
              os_cnt   <= 4'h1;
            end
          end
          ASR_START: begin
            if (os_cnt == OVS_MID) begin
              rx_state <= rx_in ? ASR_IDLE : ASR_DATA;
              os_cnt   <= OVS_MID + 4'h1;
              bit_cnt  <= '0;
            end
          end
          ASR_DATA: begin
            if (os_cnt == OVS_MID) begin
              // LSB first; eight-bit frames end up right-aligned below
              receive_shift_register <= {rx_in, receive_shift_register[8:1]}; // RULE6
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt + 4'h1 == nbits)
                rx_state <= ASR_STOP;
            end
          end
          ASR_STOP: begin
            if (os_cnt == OVS_MID) begin
              stop_evt <= 1'b1;
              stop_low <= !rx_in; // RULE15
              rx_state <= ASR_IDLE;
              if (!rcsc[B_RX9])
                receive_shift_register <= {1'b0, receive_shift_register[8:1]};
            end
          end
          default: rx_state <= ASR_IDLE;
        endcase
      end
    end
  end

  // Address mode with nine-bit frames drops characters whose ninth bit is clear
  logic addr_ok;
  logic push;
  assign addr_ok = !(rcsc[B_ADEN] && rcsc[B_RX9]) || receive_shift_register[8]; // RULE3
  assign push    = stop_evt && addr_ok && !overrun_error && fifo_in_ready; // RULE8 RULE13

  // Overrun: set on full buffer, cleared only when receive enable drops
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      overrun_error <= 1'b0;
      continuous_receive_enable_q        <= 1'b0;
    end else begin
      continuous_receive_enable_q <= rcsc[B_CONTINUOUS_RECEIVE_ENABLE];
      if (stop_evt && addr_ok && !fifo_in_ready)
        overrun_error <= 1'b1; // RULE12
      else if (!rcsc[B_CONTINUOUS_RECEIVE_ENABLE])
        overrun_error <= 1'b0; // RULE14
    end
  end

  asr_fifo #(
    .WIDTH (10),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .flush     (!rcsc[B_SERIAL_PORT_ENABLE]),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({stop_low, receive_shift_register}), // RULE16 RULE11
    .out_valid (fifo_out_valid),
    .out_ready (rd_buf),
    .out_data  (fifo_out)
  );

  // ==========================================
  // Transmit staging
  logic       tx_valid;
  logic       tx_ready;
  logic [8:0] tx_word;
  logic       tx_load;
  logic [3:0] tx_bits;
  logic [3:0] tx_os;
  logic [10:0] transmit_shift_register;
  logic       tx_busy;

  asr_fifo #(
    .WIDTH (9),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .flush     (1'b0),
    .in_valid  (wr_tx),
    .in_ready  (tx_ready),
    .in_data   ({txsc[0], reg_wdata}),
    .out_valid (tx_valid),
    .out_ready (tx_load),
    .out_data  (tx_word)
  );

  assign tx_load = tx_valid && !tx_busy && txsc[5] && serial_on && !sync_mode && os_tick;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_busy                 <= 1'b0;
      tx_bits                 <= '0;
      tx_os                   <= '0;
      transmit_shift_register <= '1;
    end else if (tx_load) begin
      tx_busy                 <= 1'b1;
      tx_os                   <= '0;
      tx_bits                 <= txsc[6] ? 4'hB : 4'hA;
      transmit_shift_register <= txsc[6] ? {1'b1, tx_word, 1'b0} : {2'b11, tx_word[7:0], 1'b0};
    end else if (tx_busy && os_tick) begin
      tx_os <= tx_os + 4'h1;
      if (tx_os == OVS_LAST) begin
        transmit_shift_register <= {1'b1, transmit_shift_register[10:1]};
        tx_bits <= tx_bits - 4'h1;
        if (tx_bits == 4'h1)
          tx_busy <= 1'b0;
      end
    end
  end

  // ==========================================
  // Outputs and read data
  logic receive_irq_flag;
  assign receive_irq_flag = fifo_out_valid; // RULE10 RULE8

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      transmit_clock_pin    <= 1'b1;
      transmit_clock_pin_oe <= 1'b0;
      receive_irq           <= 1'b0;
    end else begin
      transmit_clock_pin    <= transmit_shift_register[0];
      transmit_clock_pin_oe <= serial_on; // RULE2
      receive_irq           <= receive_irq_flag && pien[B_RECEIVE_IRQ_FLAG]; // RULE9
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_RCSC:    reg_rdata <= {rcsc[7:3], fifo_out[9] && fifo_out_valid, overrun_error,
                                   fifo_out[8] && fifo_out_valid}; // RULE16
        OFS_RXBUF:   reg_rdata <= fifo_out_valid ? fifo_out[7:0] : 8'h00;
        OFS_PIRF:    reg_rdata <= {2'b00, receive_irq_flag, 5'h00}; // RULE10
        OFS_TXSC:    reg_rdata <= {txsc[7:2], !tx_busy && !tx_valid, txsc[0]}; // RULE19
        OFS_BAUD:    reg_rdata <= baud_divisor;
        OFS_PIEN:    reg_rdata <= pien;
        OFS_INTCTL:  reg_rdata <= intctl;
        OFS_PORTDIR: reg_rdata <= portdir;
        default:     reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// file: verification/asr_top_properties.sv
`default_nettype none
module asr_top_properties
  import asr_pkg::*;
(
  // Watched ports
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       receive_data_pin,
  input wire logic       transmit_clock_pin,
  input wire logic       transmit_clock_pin_oe,
  input wire logic       receive_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ==========
  // Shadows of software writes
  logic       ie_q;
  logic       serial_port_enable_q;
  logic       txw_q;
  logic [7:0] baud_q;
  logic [7:0] dir_q;
  logic       own_q;
  assign own_q = serial_port_enable_q & dir_q[B_RXPIN] & dir_q[B_TXPIN];
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ie_q   <= 1'b0;
      serial_port_enable_q <= 1'b0;
      txw_q  <= 1'b0;
      baud_q <= RST_ZERO;
      dir_q  <= RST_PORTDIR;
    end else if (reg_wr) begin
      if (reg_addr == OFS_PIEN) ie_q <= reg_wdata[B_RECEIVE_IRQ_FLAG];
      if (reg_addr == OFS_RCSC) serial_port_enable_q <= reg_wdata[B_SERIAL_PORT_ENABLE];
      if (reg_addr == OFS_TXDATA) txw_q <= 1'b1;
      if (reg_addr == OFS_BAUD) baud_q <= reg_wdata;
      if (reg_addr == OFS_PORTDIR) dir_q <= reg_wdata;
    end
  end
  // ==========
  // Properties
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == RST_ZERO;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
  property p_unmapped;
    $past(reg_rd && reg_addr == 8'h55) |-> reg_rdata == RST_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_baud_read;
    $past(reg_rd && reg_addr == OFS_BAUD) |-> reg_rdata == $past(baud_q);
  endproperty
  a_baud_read: assert property (p_baud_read) else $error("baud divisor readback wrong");
  property p_txsc_fixed;
    $past(reg_rd && reg_addr == OFS_TXSC) |-> !reg_rdata[3] && (reg_rdata[B_TX_SHIFT_EMPTY] || $past(txw_q));
  endproperty
  a_txsc_fixed: assert property (p_txsc_fixed) else $error("transmit status bits wrong");
  property p_txpin_idle;
    !txw_q |-> transmit_clock_pin;
  endproperty
  a_txpin_idle: assert property (p_txpin_idle) else $error("transmit pin not idle");
  property p_irq_mask;
    receive_irq |-> $past(ie_q);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq without enable");
  property p_pin_owner;
    transmit_clock_pin_oe == $past(own_q);
  endproperty
  a_pin_owner: assert property (p_pin_owner) else $error("pin ownership wrong");
  property p_irq_fall;
    $fell(receive_irq) |-> $past(reg_rd || reg_wr, 2) || $past(reg_rd || reg_wr, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
endmodule
bind asr_top asr_top_properties u_props (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .receive_data_pin(receive_data_pin), .transmit_clock_pin(transmit_clock_pin),
  .transmit_clock_pin_oe(transmit_clock_pin_oe), .receive_irq(receive_irq));
`default_nettype wire

// file: verification/asr_line_tx.sv
`default_nettype none
module asr_line_tx (
  // Line side
  input  wire logic clock,
  output var  logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Remote sender, idle high between frames
  initial line = 1'b1;
  task automatic send(input logic [7:0] d, input logic stp, input int bit_clks);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= f[i];
      repeat (bit_clks) @(posedge clock);
    end
    line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: verification/asr_top_tb.sv
`default_nettype none
module asr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import asr_pkg::*;
  logic       clock;
  logic       sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       rx_line;
  logic       tx_pin;
  logic       tx_oe;
  logic       receive_irq;
  int         bad_count;
  int         n_tests;
  asr_top DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .receive_data_pin(rx_line),
    .transmit_clock_pin(tx_pin), .transmit_clock_pin_oe(tx_oe), .receive_irq(receive_irq));
  asr_line_tx line_tx (.clock(clock), .line(rx_line));
  // ==========
  // Bus and compare helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge clock);
  endtask
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_regs;
    logic [7:0] a [7] = '{OFS_INTCTL, OFS_PIRF, OFS_RCSC, OFS_PIEN, OFS_TXSC, OFS_BAUD, OFS_PORTDIR};
    logic [7:0] e [7] = '{RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_TXSC, RST_ZERO, RST_PORTDIR};
    foreach (a[i]) rd(a[i], e[i]);
    wr(OFS_BAUD, 8'hA5);
    rd(OFS_BAUD, 8'hA5);
    wr(8'h55, 8'hFF);
    rd(8'h55, RST_ZERO);
    wr(OFS_PIRF, 8'h20);
    rd(OFS_PIRF, RST_ZERO);
    wr(OFS_TXSC, 8'hFF);
    rd(OFS_TXSC, 8'hF7);
    wr(OFS_TXSC, 8'h04);
    wr(OFS_BAUD, RST_ZERO);
  endtask
  task automatic t_pin_owner;
    wr(OFS_RCSC, 8'h80);
    settle();
    chk({7'h00, tx_oe}, 8'h01);
    wr(OFS_PORTDIR, 8'hDF);
    settle();
    chk({7'h00, tx_oe}, 8'h00);
    wr(OFS_PORTDIR, 8'hFB);
    settle();
    chk({7'h00, tx_oe}, 8'h00);
    wr(OFS_PORTDIR, 8'hFF);
  endtask
  task automatic t_rx_basic;
    line_tx.send(8'h3C, 1'b1, 16);
    rd(OFS_PIRF, RST_ZERO);
    wr(OFS_TXSC, 8'h00);
    wr(OFS_RCSC, 8'h90);
    line_tx.send(8'hC3, 1'b1, 64);
    settle();
    chk({7'h00, receive_irq}, 8'h00);
    rd(OFS_PIRF, 8'h20);
    rd(OFS_RXBUF, 8'hC3);
    wr(OFS_TXSC, 8'h04);
  endtask
  task automatic t_overrun;
    wr(OFS_PIEN, 8'h20);
    line_tx.send(8'h3C, 1'b1, 16);
    line_tx.send(8'hA5, 1'b1, 16);
    settle();
    chk({7'h00, receive_irq}, 8'h01);
    line_tx.send(8'h77, 1'b1, 16);
    rd(OFS_RCSC, 8'h92);
    rd(OFS_RXBUF, 8'h3C);
    settle();
    chk({7'h00, receive_irq}, 8'h01);
    rd(OFS_RXBUF, 8'hA5);
    settle();
    chk({7'h00, receive_irq}, 8'h00);
    line_tx.send(8'h11, 1'b1, 16);
    rd(OFS_PIRF, RST_ZERO);
    wr(OFS_RCSC, 8'h80);
    wr(OFS_RCSC, 8'h90);
    rd(OFS_RCSC, 8'h90);
  endtask
  task automatic t_framing;
    line_tx.send(8'h3C, 1'b1, 16);
    line_tx.send(8'h5A, 1'b0, 16);
    rd(OFS_RCSC, 8'h90);
    rd(OFS_RXBUF, 8'h3C);
    rd(OFS_RCSC, 8'h94);
    rd(OFS_RXBUF, 8'h5A);
  endtask
  task automatic t_tx;
    logic [9:0] f;
    f = {1'b1, 8'hA5, 1'b0};
    wr(OFS_TXSC, 8'h24);
    wr(OFS_TXDATA, 8'hA5);
    rd(OFS_TXSC, 8'h24);
    repeat (6) @(posedge clock);
    #1 chk({7'h00, tx_pin}, {7'h00, f[0]});
    for (int i = 1; i < 10; i++) begin
      repeat (16) @(posedge clock);
      #1 chk({7'h00, tx_pin}, {7'h00, f[i]});
    end
    repeat (16) @(posedge clock);
    rd(OFS_TXSC, 8'h26);
  endtask
  // ==========
  // Clock, reset, sequence, watchdog
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bad_count = 0;
    n_tests = 0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_pin_owner();
    t_rx_basic();
    t_overrun();
    t_framing();
    t_tx();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
